// >>> dv/can_tx_ack_abort_status_tb_top.sv
// Testbench of the transmit result block with a frame engine model
`timescale 1ns/100ps
`default_nettype none
`include "cta_regs.svh"

module can_tx_ack_abort_status_tb_top
    import cta_pkg::*;
;
    logic clk = 1'b0; // 20 MHz clock
    logic rstn = 1'b0; // Active low reset
    logic [5:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid, st_valid, st_ready, irq_tx, irq_gbl;
    logic [4:0] st_idx;
    cta_tx_result_t result;
    cta_rmt_hit_t rmt_hit = '0; // Remote frame hits
    logic [30:0] auto_en = '0; // Automatic answer enables
    logic fail = 1'b0; // Engine reports failures while high
    logic [7:0] starts, s;
    int bad_count = 0, comparisons = 0, cycles = 0;

    cta_tx_ack_abort i_cta_tx_ack_abort (.SYS_CLK(clk), .RSTN(rstn), .CE(1'b1),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(aw_ready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(w_ready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(ar_ready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(r_valid),
        .S_AXI_RREADY(rready), .TX_START_VALID(st_valid), .TX_START_READY(st_ready),
        .TX_START_IDX(st_idx), .TX_RESULT(result), .RMT_HIT(rmt_hit),
        .AUTO_REMOTE_ANSWER_ENABLE(auto_en), .TX_COMPLETE_IRQ(irq_tx), .GLOBAL_IRQ(irq_gbl));
    cta_engine_model i_cta_engine_model (.clk(clk), .rstn(rstn), .start_valid(st_valid),
        .start_idx(st_idx), .fail_i(fail), .ready(st_ready), .result(result), .starts(starts));

    // Clock and hang watchdog
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count++;
            results();
        end
    end

    // Verdict
    task results();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Compares: words and single flags
    task chk32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // Bus write: ready sampled at the falling edge, acted on at the next rising edge
    task wr(input logic [5:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk);
            ta = awvalid && aw_ready;
            tw = wvalid && w_ready;
            tb = b_valid;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end
    endtask

    // Bus read with data and response taken at the answer edge
    task rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ta, tr;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge clk);
            ta = arvalid && ar_ready;
            tr = r_valid;
            v = rdata;
            rs = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end
    endtask
    task rdchk(input logic [5:0] a, input logic [31:0] exp);
        rd(a, d, r);
        chk32(d, exp);
    endtask

    // Bounded polls on a register bit and on the engine's start count
    task poll(input logic [5:0] a, input logic [31:0] m);
        d = '0;
        for (int i = 0; i < 100 && (d & m) == 0; i++) rd(a, d, r);
    endtask
    task wait_starts(input logic [7:0] n);
        for (int i = 0; i < 300 && starts < n; i++) @(posedge clk);
        chk1(starts >= n, 1'b1);
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdchk(`CTA_OFF_SUCCESS, 32'h0000_0000);
        rdchk(`CTA_OFF_ABORT, 32'h0000_0000);
        rdchk(`CTA_OFF_HOLD, 32'h0000_0000);
        rd(6'h24, d, r);
        chk32({30'h0, r}, {30'h0, `CTA_RESP_SLVERR});
        wr(6'h24, 32'h0000_0000);
        chk32({30'h0, r}, {30'h0, `CTA_RESP_SLVERR});
        wr(`CTA_OFF_HOLD, 32'hFFFF_FFFF);
        rdchk(`CTA_OFF_HOLD, 32'h7FFF_FFFF);
        wr(`CTA_OFF_HOLD, 32'h0000_0000);
        $display("test registers done");
        // Boundary mailboxes 0 and 30, completion interrupt
        wr(`CTA_OFF_MBX_MASK, 32'h4000_0001);
        foreach (d[k]) if (k == 0 || k == 30) begin
            wr(`CTA_OFF_REQ_SET, 32'h1 << k);
            poll(`CTA_OFF_SUCCESS, 32'h1 << k);
        end
        rdchk(`CTA_OFF_SUCCESS, 32'h4000_0001);
        chk1(irq_tx, 1'b1);
        wr(`CTA_OFF_SUCCESS, 32'h0000_0000);
        rdchk(`CTA_OFF_SUCCESS, 32'h4000_0001);
        wr(`CTA_OFF_SUCCESS, 32'h8000_0001);
        rdchk(`CTA_OFF_SUCCESS, 32'h4000_0000);
        wr(`CTA_OFF_MBX_FLAG, 32'h7FFF_FFFF);
        chk1(irq_tx, 1'b0);
        $display("test success done");
        // Held mailbox: skipped, cancelled while idle, abort flag clears
        wr(`CTA_OFF_HOLD, 32'h0000_0008);
        s = starts;
        wr(`CTA_OFF_REQ_SET, 32'h0000_0008);
        repeat (10) @(posedge clk);
        chk32({24'h0, starts}, {24'h0, s});
        wr(`CTA_OFF_REQ_RESET, 32'h0000_0008);
        rdchk(`CTA_OFF_ABORT, 32'h0000_0008);
        rdchk(`CTA_OFF_REQ_SET, 32'h0000_0000);
        wr(`CTA_OFF_GBL_MASK, 32'h0000_0001);
        chk1(irq_gbl, 1'b1);
        wr(`CTA_OFF_REQ_SET, 32'h0000_0008);
        rdchk(`CTA_OFF_ABORT, 32'h0000_0000);
        wr(`CTA_OFF_REQ_RESET, 32'h0000_0008);
        wr(`CTA_OFF_ABORT, 32'h0000_0000);
        rdchk(`CTA_OFF_ABORT, 32'h0000_0008);
        wr(`CTA_OFF_ABORT, 32'h0000_0008);
        rdchk(`CTA_OFF_ABORT, 32'h0000_0000);
        wr(`CTA_OFF_GBL_FLAG, 32'h0000_0001);
        chk1(irq_gbl, 1'b0);
        $display("test hold done");
        // Remote answer held during a data rewrite, then released
        auto_en[7] <= 1'b1;
        wr(`CTA_OFF_HOLD, 32'h0000_0080);
        rmt_hit <= '{1'b1, 5'd7};
        @(posedge clk);
        rmt_hit <= '{1'b1, 5'd31};
        @(posedge clk);
        rmt_hit <= '{1'b1, 5'd9};
        @(posedge clk);
        rmt_hit <= '0;
        rdchk(`CTA_OFF_REQ_SET, 32'h0000_0080);
        wr(`CTA_OFF_HOLD, 32'h0000_0000);
        poll(`CTA_OFF_SUCCESS, 32'h0000_0080);
        rdchk(`CTA_OFF_SUCCESS, 32'h4000_0080);
        $display("test remote done");
        // Failed frames retried, then a cancel during a failing frame
        fail <= 1'b1;
        s = starts;
        wr(`CTA_OFF_REQ_SET, 32'h0000_0002);
        wait_starts(s + 8'h03);
        rdchk(`CTA_OFF_REQ_SET, 32'h0000_0002);
        fail <= 1'b0;
        poll(`CTA_OFF_SUCCESS, 32'h0000_0002);
        rdchk(`CTA_OFF_SUCCESS, 32'h4000_0082);
        fail <= 1'b1;
        wr(`CTA_OFF_REQ_SET, 32'h0000_0004);
        wait_starts(starts + 8'h01);
        wr(`CTA_OFF_REQ_RESET, 32'h0000_0004);
        poll(`CTA_OFF_ABORT, 32'h0000_0004);
        rdchk(`CTA_OFF_ABORT, 32'h0000_0004);
        rdchk(`CTA_OFF_REQ_SET, 32'h0000_0000);
        $display("test retry done");
        results();
    end
endmodule

`default_nettype wire

// >>> dv/cta_engine_model.sv
// Frame engine model: takes starts, reports each frame outcome after a delay
`timescale 1ns/100ps
`default_nettype none
`include "cta_regs.svh"

module cta_engine_model
    import cta_pkg::*;
#(
    parameter int DLY = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start_valid,
    input wire logic [`CTA_IDX_W-1:0] start_idx,
    input wire logic fail_i,
    output logic ready,
    output cta_tx_result_t result,
    output logic [7:0] starts
);
    logic busy_q; // Frame on the bus
    int cnt_q; // Cycles left in the frame

    // One frame at a time, as a real engine
    assign ready = !busy_q;

    // Frame timing; ok toggles between results so a stale value is never trusted
    always_ff @(posedge clk) begin
        result.valid <= 1'b0;
        result.ok <= ~result.ok;
        if (!rstn) begin
            busy_q <= 1'b0;
            cnt_q <= 0;
            starts <= 8'h00;
        end else if (start_valid && !busy_q) begin
            busy_q <= 1'b1;
            cnt_q <= DLY;
            starts <= starts + 8'h01;
        end else if (busy_q && cnt_q == 0) begin
            busy_q <= 1'b0;
            result.valid <= 1'b1;
            result.ok <= !fail_i;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 1;
        end
    end
endmodule

`default_nettype wire

// >>> logic/cta_arbiter.sv
// Internal transmit arbitration over mailboxes with pending requests
`timescale 1ns/100ps
`default_nettype none
`include "cta_regs.svh"

module cta_arbiter
    import cta_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [`CTA_MBX_N-1:0] pend_i,
    input wire logic busy_i,
    output logic start_valid,
    output logic [`CTA_IDX_W-1:0] start_idx_q
);

    logic cand_q; // A candidate was found last cycle

    // Candidate picked one cycle ahead so the index comes from a flop
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cand_q <= 1'b0;
            start_idx_q <= '0;
        end else if (ce) begin
            cand_q <= |pend_i; // R11
            start_idx_q <= cta_first(pend_i);
        end
    end

    // Recheck the live pending set: a hold raised late still blocks the start
    assign start_valid = cand_q && !busy_i && pend_i[start_idx_q]; // R10

    only_pending_a: assert property (@(posedge clk) disable iff (!rstn) // R10
        start_valid |-> pend_i[start_idx_q] && !busy_i)
        else $error("start offered for a mailbox that is not eligible");

endmodule
`default_nettype wire

// >>> logic/cta_flag_bank.sv
// Sticky flag bank: hardware sets, software clears, set wins
`timescale 1ns/100ps
`default_nettype none
`include "cta_regs.svh"

module cta_flag_bank
    import cta_pkg::*;
#(
    parameter int W = `CTA_MBX_N
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] flag_q
);

    logic [W-1:0] flag_d; // Next flag value

    // Clear first, then set, so a same-cycle event survives
    always_comb begin
        flag_d = (flag_q & ~clr_i) | set_i; // R16
    end

    // Flags hold while the clock enable is low
    always_ff @(posedge clk) begin
        if (!rstn) begin
            flag_q <= '0;
        end else if (ce) begin
            flag_q <= flag_d;
        end
    end

    set_wins_a: assert property (@(posedge clk) disable iff (!rstn) // R16
        (ce && (set_i & clr_i) != '0) |=> ((flag_q & $past(set_i & clr_i)) == $past(set_i & clr_i)))
        else $error("clear beat a same-cycle set");

endmodule
`default_nettype wire

// >>> logic/cta_pkg.sv
// Types and shared helper functions of the transmit result block
`default_nettype none
`include "cta_regs.svh"

package cta_pkg;

    // Outcome of one frame attempt reported by the frame engine
    typedef struct packed {
        logic valid;
        logic ok;
    } cta_tx_result_t;

    // Matching remote frame received for a mailbox
    typedef struct packed {
        logic valid;
        logic [`CTA_IDX_W-1:0] idx;
    } cta_rmt_hit_t;

    // Mailbox index to one-hot vector, index 31 falls off the top
    function automatic logic [`CTA_MBX_N-1:0] cta_onehot(input logic [`CTA_IDX_W-1:0] idx);
        logic [`CTA_MBX_N:0] v;
        v = '0;
        v[idx] = 1'b1;
        return v[`CTA_MBX_N-1:0];
    endfunction

    // Lowest set bit wins: mailbox 0 has the highest priority
    function automatic logic [`CTA_IDX_W-1:0] cta_first(input logic [`CTA_MBX_N-1:0] vec);
        logic [`CTA_IDX_W-1:0] r;
        r = '0;
        for (int i = `CTA_MBX_N - 1; i >= 0; i--) begin
            if (vec[i]) begin
                r = i[`CTA_IDX_W-1:0];
            end
        end
        return r;
    endfunction

endpackage
`default_nettype wire

// >>> logic/cta_regs.svh
// Register offsets, field positions and reset values of the transmit result block
`ifndef CTA_REGS_SVH
`define CTA_REGS_SVH

// Byte offsets of the register words
`define CTA_OFF_SUCCESS 6'h00
`define CTA_OFF_ABORT 6'h04
`define CTA_OFF_HOLD 6'h08
`define CTA_OFF_REQ_SET 6'h0C
`define CTA_OFF_REQ_RESET 6'h10
`define CTA_OFF_MBX_MASK 6'h14
`define CTA_OFF_MBX_FLAG 6'h18
`define CTA_OFF_GBL_FLAG 6'h1C
`define CTA_OFF_GBL_MASK 6'h20

// Address and mailbox geometry
`define CTA_ADDR_W 6
`define CTA_MBX_N 31
`define CTA_IDX_W 5

// Field positions and reset values
`define CTA_GBL_ABORT_BIT 0
`define CTA_RST_MBX 31'h0000_0000
`define CTA_RST_BIT 1'h0

// Bus answers
`define CTA_RESP_OKAY 2'h0
`define CTA_RESP_SLVERR 2'h2

`endif

// >>> logic/cta_tx_ack_abort.sv
// Transmit acknowledge, abort acknowledge and data-change hold per mailbox
// What this block does
// R1: Bits 30..0 map to same-index mailboxes.
// R2: Bit 31 reads zero in all three.
// R3: Mailbox 31 gets no transmit bits.
// R4: Successful transmission sets the acknowledge bit.
// R5: Write one to acknowledge or request clears.
// R6: Masked acknowledge sets flag, raises completion interrupt.
// R7: Cancel of an idle request, or failure of a frame with a cancel pending, sets abort bit.
// R8: Abort flag with mask raises global interrupt.
// R9: Write one to abort or request clears.
// R10: Held mailbox is skipped by arbitration.
// R11: Releasing the hold rejoins arbitration.
// R12: Matching remote frame starts automatic transmission.
// R13: Software holds mailbox while rewriting answered data.
// R14: Cancel before start clears requests, sets abort.
// R15: Failed transmission retried until success or cancel.
// R16: Hardware set beats same-cycle software clear.
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "cta_regs.svh"

module cta_tx_ack_abort
    import cta_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic CE,
    // Register bus
    input wire logic [`CTA_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [`CTA_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Frame engine side
    output logic TX_START_VALID,
    input wire logic TX_START_READY,
    output logic [`CTA_IDX_W-1:0] TX_START_IDX,
    input wire cta_tx_result_t TX_RESULT,
    input wire cta_rmt_hit_t RMT_HIT,
    input wire logic [`CTA_MBX_N-1:0] AUTO_REMOTE_ANSWER_ENABLE,
    // Interrupts
    output logic TX_COMPLETE_IRQ,
    output logic GLOBAL_IRQ
);

    // Write channel holding state
    logic aw_have_q; // Address captured
    logic w_have_q; // Data captured
    logic [`CTA_ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    // Read channel state
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    // Mailbox state, 31 bits wide: mailbox 31 has none
    logic [`CTA_MBX_N-1:0] trs_q; // Pending transmit requests
    logic [`CTA_MBX_N-1:0] trr_q; // Cancel waiting on an active frame
    logic [`CTA_MBX_N-1:0] hold_q; // Data-change hold
    logic [`CTA_MBX_N-1:0] imask_q; // Mailbox interrupt mask
    logic gmask_q; // Transmit abort interrupt mask
    logic active_q; // A frame is on the wire
    logic [`CTA_IDX_W-1:0] act_idx_q; // Mailbox of that frame

    // Flag bank outputs
    logic [`CTA_MBX_N-1:0] ta_q;
    logic [`CTA_MBX_N-1:0] aa_q;
    logic [`CTA_MBX_N-1:0] mbtif_q;
    logic gflag_q;

    // Decoded write and per-cycle events
    logic wen; // Register write happens this cycle
    logic [31:0] bmask; // Byte lanes expanded to bits
    logic [`CTA_MBX_N-1:0] wbits; // Written ones on enabled lanes
    logic wr_ta, wr_aa, wr_hold, wr_set, wr_rst, wr_imask, wr_mbf, wr_gf, wr_gm;
    logic [`CTA_MBX_N-1:0] act_oh; // Active mailbox, one-hot
    logic [`CTA_MBX_N-1:0] req_set; // Requests raised this cycle
    logic [`CTA_MBX_N-1:0] cancel_now; // Cancels of idle requests
    logic [`CTA_MBX_N-1:0] ta_set, aa_set, ta_clr, aa_clr;
    logic res_ok, res_fail, start;

    // Known offset check, shared by read and write decode
    function automatic logic reg_known(input logic [`CTA_ADDR_W-1:0] a);
        logic [`CTA_ADDR_W-1:0] w;
        w = {a[`CTA_ADDR_W-1:2], 2'h0};
        return w == `CTA_OFF_SUCCESS || w == `CTA_OFF_ABORT || w == `CTA_OFF_HOLD ||
               w == `CTA_OFF_REQ_SET || w == `CTA_OFF_REQ_RESET || w == `CTA_OFF_MBX_MASK ||
               w == `CTA_OFF_MBX_FLAG || w == `CTA_OFF_GBL_FLAG || w == `CTA_OFF_GBL_MASK;
    endfunction

    // Word select on the aligned address
    function automatic logic hit(input logic [`CTA_ADDR_W-1:0] a,
                                 input logic [`CTA_ADDR_W-1:0] off);
        return {a[`CTA_ADDR_W-1:2], 2'h0} == off;
    endfunction

    // Handshake outputs; nothing is taken while the clock enable is low
    assign S_AXI_AWREADY = CE && !aw_have_q;
    assign S_AXI_WREADY = CE && !w_have_q;
    assign S_AXI_ARREADY = CE && !rvalid_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RRESP = rresp_q;
    assign S_AXI_RDATA = rdata_q;

    // Write commits once both halves are in and the last answer is gone
    assign wen = CE && aw_have_q && w_have_q && !bvalid_q;

    // Decode of the write word and the core events
    always_comb begin
        bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
        wbits = wdata_q[`CTA_MBX_N-1:0] & bmask[`CTA_MBX_N-1:0]; // R1 R2
        wr_ta = wen && hit(awaddr_q, `CTA_OFF_SUCCESS);
        wr_aa = wen && hit(awaddr_q, `CTA_OFF_ABORT);
        wr_hold = wen && hit(awaddr_q, `CTA_OFF_HOLD);
        wr_set = wen && hit(awaddr_q, `CTA_OFF_REQ_SET);
        wr_rst = wen && hit(awaddr_q, `CTA_OFF_REQ_RESET);
        wr_imask = wen && hit(awaddr_q, `CTA_OFF_MBX_MASK);
        wr_mbf = wen && hit(awaddr_q, `CTA_OFF_MBX_FLAG);
        wr_gf = wen && hit(awaddr_q, `CTA_OFF_GBL_FLAG);
        wr_gm = wen && hit(awaddr_q, `CTA_OFF_GBL_MASK);
        act_oh = active_q ? cta_onehot(act_idx_q) : '0;
        start = CE && TX_START_VALID && TX_START_READY;
        res_ok = CE && active_q && TX_RESULT.valid && TX_RESULT.ok;
        res_fail = CE && active_q && TX_RESULT.valid && !TX_RESULT.ok;
        // Remote answer and software both raise requests
        req_set = wr_set ? wbits : '0;
        if (CE && RMT_HIT.valid) begin
            req_set = req_set | (cta_onehot(RMT_HIT.idx) & AUTO_REMOTE_ANSWER_ENABLE); // R12 R3
        end
        // Cancel of a request whose frame has not begun finishes at once
        cancel_now = wr_rst ? (wbits & trs_q & ~act_oh) : '0; // R14
        ta_set = res_ok ? act_oh : '0; // R4
        aa_set = cancel_now;
        if (res_fail && (trr_q & act_oh) != '0) begin
            aa_set = aa_set | act_oh; // R7
        end
        ta_clr = (wr_ta || wr_set) ? wbits : '0; // R5
        aa_clr = (wr_aa || wr_set) ? wbits : '0; // R9
    end

    // Write address capture
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            aw_have_q <= 1'b0;
            awaddr_q <= '0;
        end else if (CE) begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR;
            end else if (wen) begin
                aw_have_q <= 1'b0;
            end
        end
    end

    // Write data capture
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            w_have_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (CE) begin
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_q <= 1'b1;
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
            end else if (wen) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // Write response, unmapped words answer with an error
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            bvalid_q <= 1'b0;
            bresp_q <= `CTA_RESP_OKAY;
        end else if (CE) begin
            if (wen) begin
                bvalid_q <= 1'b1;
                bresp_q <= reg_known(awaddr_q) ? `CTA_RESP_OKAY : `CTA_RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read data, bit 31 and unused upper bits always read zero
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            rvalid_q <= 1'b0;
            rresp_q <= `CTA_RESP_OKAY;
            rdata_q <= '0;
        end else if (CE) begin
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                rvalid_q <= 1'b1;
                rresp_q <= reg_known(S_AXI_ARADDR) ? `CTA_RESP_OKAY : `CTA_RESP_SLVERR;
                rdata_q <= '0;
                unique case ({S_AXI_ARADDR[`CTA_ADDR_W-1:2], 2'h0})
                    `CTA_OFF_SUCCESS: rdata_q <= {1'b0, ta_q}; // R2 R3
                    `CTA_OFF_ABORT: rdata_q <= {1'b0, aa_q}; // R2
                    `CTA_OFF_HOLD: rdata_q <= {1'b0, hold_q}; // R2
                    `CTA_OFF_REQ_SET: rdata_q <= {1'b0, trs_q};
                    `CTA_OFF_REQ_RESET: rdata_q <= {1'b0, trr_q};
                    `CTA_OFF_MBX_MASK: rdata_q <= {1'b0, imask_q};
                    `CTA_OFF_MBX_FLAG: rdata_q <= {1'b0, mbtif_q};
                    `CTA_OFF_GBL_FLAG: rdata_q[`CTA_GBL_ABORT_BIT] <= gflag_q;
                    `CTA_OFF_GBL_MASK: rdata_q[`CTA_GBL_ABORT_BIT] <= gmask_q;
                    default: rdata_q <= '0; // Unmapped word
                endcase
            end else if (S_AXI_RREADY) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Plain read/write control words, byte lanes honoured
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            hold_q <= `CTA_RST_MBX;
            imask_q <= `CTA_RST_MBX;
            gmask_q <= `CTA_RST_BIT;
        end else if (CE) begin
            if (wr_hold) begin
                // Software sets this around data rewrites of answering mailboxes
                hold_q <= (hold_q & ~bmask[`CTA_MBX_N-1:0]) | wbits; // R13 R11
            end
            if (wr_imask) begin
                imask_q <= (imask_q & ~bmask[`CTA_MBX_N-1:0]) | wbits;
            end
            if (wr_gm && bmask[`CTA_GBL_ABORT_BIT]) begin
                gmask_q <= wdata_q[`CTA_GBL_ABORT_BIT];
            end
        end
    end

    // Transmit requests: cleared on success or abort, kept on plain failure
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            trs_q <= `CTA_RST_MBX;
        end else if (CE) begin
            trs_q <= (trs_q | req_set) & ~(ta_set | aa_set); // R15 R14
        end
    end

    // Cancel of an active frame waits for its outcome
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            trr_q <= `CTA_RST_MBX;
        end else if (CE) begin
            trr_q <= (trr_q | (wr_rst ? (wbits & trs_q & act_oh) : '0)) & ~(ta_set | aa_set);
        end
    end

    // Active frame tracking; a failed frame returns to arbitration
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            active_q <= 1'b0;
            act_idx_q <= '0;
        end else if (CE) begin
            if (start) begin
                active_q <= 1'b1;
                act_idx_q <= TX_START_IDX;
            end else if (res_ok || res_fail) begin
                active_q <= 1'b0; // R15
            end
        end
    end

    // Arbitration over pending requests that are not held
    cta_arbiter u_arb (
        .clk(SYS_CLK), .rstn(RSTN), .ce(CE),
        .pend_i(trs_q & ~hold_q), // R10 R11
        .busy_i(active_q),
        .start_valid(TX_START_VALID), .start_idx_q(TX_START_IDX)
    );

    // Transmit acknowledge flags
    cta_flag_bank #(.W(`CTA_MBX_N)) u_ta (
        .clk(SYS_CLK), .rstn(RSTN), .ce(CE),
        .set_i(ta_set), .clr_i(ta_clr),
        .flag_q(ta_q)
    );

    // Abort acknowledge flags
    cta_flag_bank #(.W(`CTA_MBX_N)) u_aa (
        .clk(SYS_CLK), .rstn(RSTN), .ce(CE),
        .set_i(aa_set), .clr_i(aa_clr),
        .flag_q(aa_q)
    );

    // Mailbox transmit interrupt flags, only for unmasked mailboxes
    cta_flag_bank #(.W(`CTA_MBX_N)) u_mbf (
        .clk(SYS_CLK), .rstn(RSTN), .ce(CE),
        .set_i(ta_set & imask_q), // R6
        .clr_i(wr_mbf ? wbits : '0),
        .flag_q(mbtif_q)
    );

    // Global transmit abort flag, set by any abort acknowledge
    cta_flag_bank #(.W(1)) u_gf (
        .clk(SYS_CLK), .rstn(RSTN), .ce(CE),
        .set_i(|aa_set), // R8
        .clr_i(wr_gf && bmask[`CTA_GBL_ABORT_BIT] && wdata_q[`CTA_GBL_ABORT_BIT]),
        .flag_q(gflag_q)
    );

    // Level interrupts straight from flags and masks
    assign TX_COMPLETE_IRQ = |(mbtif_q & imask_q); // R6
    assign GLOBAL_IRQ = gflag_q && gmask_q; // R8

    // Checks on the mailbox bookkeeping
    sequence idle_cancel_s;
        CE && cancel_now != '0;
    endsequence

    top_bit_zero_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R2
        S_AXI_RVALID |-> !S_AXI_RDATA[31])
        else $error("bit 31 read back as one");
    ack_on_ok_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R4
        res_ok |=> (ta_q & $past(act_oh)) != '0 && !active_q)
        else $error("success did not set the acknowledge bit");
    req_clear_ack_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R5
        (wr_set && ta_set == '0) |=> (ta_q & $past(wbits)) == '0)
        else $error("request write left acknowledge set");
    cancel_idle_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R14
        idle_cancel_s |=> ((trs_q | trr_q) & $past(cancel_now)) == '0
                          && (aa_q & $past(cancel_now)) == $past(cancel_now))
        else $error("idle cancel did not finish at once");
    retry_kept_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R15
        (res_fail && (trr_q & act_oh) == '0) |=> (trs_q & $past(act_oh)) != '0)
        else $error("failed request was dropped without cancel");
    done_irq_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R6
        (ta_set & imask_q) != '0 |=> TX_COMPLETE_IRQ ##0 (mbtif_q & $past(ta_set)) != '0)
        else $error("unmasked acknowledge raised no completion interrupt");
    abort_irq_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R8
        (aa_set != '0 && gmask_q && !wr_gm) |=> GLOBAL_IRQ && gflag_q)
        else $error("abort raised no global interrupt");
    held_no_start_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R10
        TX_START_VALID |-> !hold_q[TX_START_IDX] && trs_q[TX_START_IDX])
        else $error("held mailbox offered for transmission");
    remote_req_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // R12
        (CE && RMT_HIT.valid && AUTO_REMOTE_ANSWER_ENABLE[RMT_HIT.idx[`CTA_IDX_W-1:0]]
         && RMT_HIT.idx != 5'h1F && ta_set == '0 && aa_set == '0)
        |=> trs_q[$past(RMT_HIT.idx)])
        else $error("remote frame did not raise a request");

endmodule
`default_nettype wire
